//--- rtl/gigabit_pcs_8b10b_codec.v
// gigabit pcs datapath: gmii octets to and from 8b/10b code-groups
// Function
// - every cycle octet_to_codegroup txd, tx_en, tx_er into a code-group for the pma
// - col asserts while receiving and transmitting together
// - keep an internal transmit-active flag for carrier sense
// - xmit selector chooses idles with packets or configuration sequences
// - crs follows transmit-active or receive-active
// - accept every incoming code-group and forward it to receive
// - sync flag true only while the incoming stream looks reliable
// - decode to rxd, rx_dv, rx_er and keep receive-active flag
// - octet-wide client path, ten-bit pma path, one code-group per clock
// - octet bits A..H map onto code bits a,b,c,d,e,i,f,g,h,j
// - data flag gives data code-group, special flag gives special
// - x is low five octet bits, y high three; 256 data groups
// - ordered sets go out special first, then the rest in order
// - ordered sets start on even positions counted from reset; /S/ here follows tx_en and can go out on an odd position
// - packet: start delimiter, data in order, then end delimiter
// - one table per disparity serves encoding and validity checking
// - running disparity is one bit in transmitter and receiver
// - emitted groups are dc-balanced with 3 to 9 transitions
// - transmitter starts negative and updates after every group
// - disparity updated six-bit block first, then four-bit block
// - invalid when absent from current column; disparity still updates
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pcs_map.vh"
module gigabit_pcs_8b10b_codec (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  txd,
  input  wire        tx_en,
  input  wire        tx_er,
  output wire [9:0]  tx_code,
  input  wire [9:0]  rx_code,
  output wire [7:0]  rxd,
  output wire        rx_dv,
  output wire        rx_er,
  output wire        col,
  output wire        crs,
  output wire        sync_ok,
  input  wire [1:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata
);
  // ----------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DATA = 5'h02;
  localparam [4:0] ST_EPR1 = 5'h04;
  localparam [4:0] ST_EPR2 = 5'h08;
  localparam [4:0] ST_CFG  = 5'h10;

  // disparity at the end of a group, six-bit block then four-bit
  function rd_after;
    input       rd;
    input [9:0] c;
    reg   [2:0] n;
    reg         m;
    integer     k;
    begin
      n = 3'h0;
      for (k = 4; k < 10; k = k + 1)
        n = n + {2'h0, c[k]};
      if (n > 3'h3 || c[9:4] == 6'b000111)
        m = 1'b1;
      else if (n < 3'h3 || c[9:4] == 6'b111000)
        m = 1'b0;
      else
        m = rd;
      n = {2'h0, c[0]} + {2'h0, c[1]} + {2'h0, c[2]} + {2'h0, c[3]};
      if (n > 3'h2 || c[3:0] == 4'b0011)
        rd_after = 1'b1;
      else if (n < 3'h2 || c[3:0] == 4'b1100)
        rd_after = 1'b0;
      else
        rd_after = m;
    end
  endfunction

  // negative-column six-bit lookup, {hit, x}
  function [5:0] dec6;
    input [5:0] c;
    begin
      case (c)
        6'b100111: dec6 = 6'h20;  6'b011101: dec6 = 6'h21;
        6'b101101: dec6 = 6'h22;  6'b110001: dec6 = 6'h23;
        6'b110101: dec6 = 6'h24;  6'b101001: dec6 = 6'h25;
        6'b011001: dec6 = 6'h26;  6'b111000: dec6 = 6'h27;
        6'b111001: dec6 = 6'h28;  6'b100101: dec6 = 6'h29;
        6'b010101: dec6 = 6'h2A;  6'b110100: dec6 = 6'h2B;
        6'b001101: dec6 = 6'h2C;  6'b101100: dec6 = 6'h2D;
        6'b011100: dec6 = 6'h2E;  6'b010111: dec6 = 6'h2F;
        6'b011011: dec6 = 6'h30;  6'b100011: dec6 = 6'h31;
        6'b010011: dec6 = 6'h32;  6'b110010: dec6 = 6'h33;
        6'b001011: dec6 = 6'h34;  6'b101010: dec6 = 6'h35;
        6'b011010: dec6 = 6'h36;  6'b111010: dec6 = 6'h37;
        6'b110011: dec6 = 6'h38;  6'b100110: dec6 = 6'h39;
        6'b010110: dec6 = 6'h3A;  6'b110110: dec6 = 6'h3B;
        6'b001110: dec6 = 6'h3C;  6'b001111: dec6 = 6'h3C;
        6'b101110: dec6 = 6'h3D;  6'b011110: dec6 = 6'h3E;
        6'b101011: dec6 = 6'h3F;
        default: dec6 = 6'h00;
      endcase
    end
  endfunction

  // four-bit lookup, {hit, y}
  function [3:0] dec4;
    input [3:0] c;
    begin
      case (c)
        4'b1011: dec4 = 4'h8;
        4'b1001: dec4 = 4'h9;
        4'b0101: dec4 = 4'hA;
        4'b1100: dec4 = 4'hB;
        4'b1101: dec4 = 4'hC;
        4'b1010: dec4 = 4'hD;
        4'b0110: dec4 = 4'hE;
        4'b1110: dec4 = 4'hF;
        4'b0111: dec4 = 4'hF;
        default: dec4 = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg        pos_ff;
  reg [1:0]  cfg_cnt_ff;
  reg [1:0]  nxt_cfg_cnt;
  reg        cfg_sel_ff;
  reg        nxt_cfg_sel;
  reg        tx_rd_ff;
  reg [9:0]  tx_code_ff;
  reg [7:0]  tx_oct;
  reg        tx_k;
  wire [9:0] tx_cg;
  reg [9:0]  rx_in_ff;
  reg        rx_rd_ff;
  reg        sync_ff;
  reg [2:0]  sync_cnt_ff;
  reg        rx_act_ff;
  reg [7:0]  rxd_ff;
  reg        rx_dv_ff;
  reg        rx_er_ff;
  reg [15:0] ctrl_ff;
  reg [15:0] cfg_ff;
  reg [15:0] bad_cnt_ff;
  reg [15:0] rdata_ff;
  wire       tx_act;
  wire       xmit_data;

  assign tx_act    = (state_ff & (ST_DATA | ST_EPR1 | ST_EPR2)) != 5'h00;
  assign xmit_data = ctrl_ff[`CTRL_XMIT_DATA];
  assign col       = tx_act & rx_act_ff;
  assign crs       = tx_act | rx_act_ff;
  assign tx_code   = tx_code_ff;
  assign rxd       = rxd_ff;
  assign rx_dv     = rx_dv_ff;
  assign rx_er     = rx_er_ff;
  assign sync_ok   = sync_ff;
  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // transmit sequencing
  // ----------------------------------------------------------------
  always @* begin
    nxt_state   = state_ff;
    nxt_cfg_cnt = cfg_cnt_ff;
    nxt_cfg_sel = cfg_sel_ff;
    tx_k        = 1'b1;
    tx_oct      = `OS_COMMA;
    case (state_ff)
      ST_IDLE: begin
        if (xmit_data && tx_en) begin
          tx_oct    = `OS_START_PKT;
          nxt_state = ST_DATA;
        end else if (pos_ff) begin
          tx_k   = 1'b0;
          tx_oct = `OS_IDLE2;
        end else if (!xmit_data) begin
          nxt_state   = ST_CFG;
          nxt_cfg_cnt = 2'h1;
        end
      end
      ST_DATA: begin
        if (tx_en && tx_er) begin
          tx_oct = `OS_ERR;
        end else if (tx_en) begin
          tx_k   = 1'b0;
          tx_oct = txd;
        end else begin
          tx_oct    = `OS_END_PKT;
          nxt_state = ST_EPR1;
        end
      end
      ST_EPR1: begin
        tx_oct    = `OS_CARRY;
        // an extra carrier code puts the next idle on an even slot
        nxt_state = pos_ff ? ST_IDLE : ST_EPR2;
      end
      ST_EPR2: begin
        tx_oct    = `OS_CARRY;
        nxt_state = ST_IDLE;
      end
      ST_CFG: begin
        tx_k        = (cfg_cnt_ff == 2'h0);
        nxt_cfg_cnt = cfg_cnt_ff + 2'h1;
        case (cfg_cnt_ff)
          2'h0: tx_oct = `OS_COMMA;
          2'h1: tx_oct = cfg_sel_ff ? `OS_CFG2 : `OS_CFG1;
          2'h2: tx_oct = cfg_ff[7:0];
          default: begin
            tx_oct      = cfg_ff[15:8];
            nxt_cfg_sel = ~cfg_sel_ff;
            if (xmit_data)
              nxt_state = ST_IDLE;
          end
        endcase
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  octet_to_codegroup tx_enc (
    .octet      (tx_oct),
    .is_special (tx_k),
    .rd_pos     (tx_rd_ff),
    .code       (tx_cg)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      pos_ff     <= 1'b0;
      cfg_cnt_ff <= 2'h0;
      cfg_sel_ff <= 1'b0;
      tx_rd_ff   <= 1'b0;
      tx_code_ff <= 10'h000;
    end else begin
      state_ff   <= nxt_state;
      pos_ff     <= ~pos_ff;
      cfg_cnt_ff <= nxt_cfg_cnt;
      cfg_sel_ff <= nxt_cfg_sel;
      tx_rd_ff   <= rd_after(tx_rd_ff, tx_cg);
      tx_code_ff <= tx_cg;
    end
  end

  // ----------------------------------------------------------------
  // receive decoding
  // ----------------------------------------------------------------
  reg  [5:0] h6;
  reg  [3:0] h4;
  reg  [3:0] s4k;
  reg        rx_k;
  wire [9:0] chk_cg;
  wire       rx_valid;
  wire       is_comma;

  // the complement lookup stands in for the positive column
  always @* begin
    h6 = dec6(rx_in_ff[9:4]);
    if (!h6[5])
      h6 = dec6(~rx_in_ff[9:4]);
    s4k = (rx_in_ff[9:4] == 6'b110000) ? ~rx_in_ff[3:0] : rx_in_ff[3:0];
    h4 = dec4(s4k);
    if (!h4[3])
      h4 = dec4(~s4k);
    rx_k = (rx_in_ff[9:4] == 6'b001111) | (rx_in_ff[9:4] == 6'b110000) |
           (((rx_in_ff[3:0] == 4'b0111) | (rx_in_ff[3:0] == 4'b1000)) &
            ((h6[4:0] == 5'h17) | (h6[4:0] == 5'h1B) | (h6[4:0] == 5'h1D) | (h6[4:0] == 5'h1E)));
  end

  // re-encoding at the current disparity is the column search
  octet_to_codegroup rx_chk (
    .octet      ({h4[2:0], h6[4:0]}),
    .is_special (rx_k),
    .rd_pos     (rx_rd_ff),
    .code       (chk_cg)
  );

  assign rx_valid = (chk_cg == rx_in_ff);
  assign is_comma = rx_valid & rx_k & ({h4[2:0], h6[4:0]} == `OS_COMMA);

  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_in_ff    <= 10'h000;
      rx_rd_ff    <= 1'b0;
      sync_ff     <= 1'b0;
      sync_cnt_ff <= 3'h0;
      rx_act_ff   <= 1'b0;
      rxd_ff      <= 8'h00;
      rx_dv_ff    <= 1'b0;
      rx_er_ff    <= 1'b0;
    end else begin
      rx_in_ff <= rx_code;
      rx_rd_ff <= rd_after(rx_rd_ff, rx_in_ff);
      // acquire on clean commas, drop after a run of invalids
      if (!sync_ff) begin
        if (!rx_valid)
          sync_cnt_ff <= 3'h0;
        else if (is_comma && sync_cnt_ff == `SYNC_ACQ - 3'h1) begin
          sync_ff     <= 1'b1;
          sync_cnt_ff <= 3'h0;
        end else if (is_comma)
          sync_cnt_ff <= sync_cnt_ff + 3'h1;
      end else begin
        if (rx_valid)
          sync_cnt_ff <= 3'h0;
        else if (sync_cnt_ff == `SYNC_LOSS - 3'h1) begin
          sync_ff     <= 1'b0;
          sync_cnt_ff <= 3'h0;
        end else
          sync_cnt_ff <= sync_cnt_ff + 3'h1;
      end
      rx_dv_ff <= 1'b0;
      rx_er_ff <= 1'b0;
      if (!sync_ff) begin
        rx_act_ff <= 1'b0;
      end else if (!rx_act_ff) begin
        if (rx_valid && rx_k && {h4[2:0], h6[4:0]} == `OS_START_PKT) begin
          rx_act_ff <= 1'b1;
          rx_dv_ff  <= 1'b1;
          rxd_ff    <= `RX_PREAMBLE;
        end
      end else if (rx_valid && rx_k && {h4[2:0], h6[4:0]} == `OS_END_PKT) begin
        rx_act_ff <= 1'b0;
      end else begin
        rx_dv_ff <= 1'b1;
        rx_er_ff <= ~rx_valid | rx_k;
        rxd_ff   <= {h4[2:0], h6[4:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff    <= `CTRL_RESET;
      cfg_ff     <= `CFG_RESET;
      bad_cnt_ff <= 16'h0000;
      rdata_ff   <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `REG_CTRL)
        ctrl_ff <= reg_wdata & 16'h0001;
      if (reg_wr && reg_addr == `REG_CFG)
        cfg_ff <= reg_wdata;
      // an invalid group in the clearing cycle still counts
      if (reg_wr && reg_addr == `REG_BADCNT)
        bad_cnt_ff <= {15'h0000, ~rx_valid};
      else if (!rx_valid && bad_cnt_ff != 16'hFFFF)
        bad_cnt_ff <= bad_cnt_ff + 16'h0001;
      rdata_ff <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `REG_CTRL)
          rdata_ff <= ctrl_ff;
        else if (reg_addr == `REG_CFG)
          rdata_ff <= cfg_ff;
        else if (reg_addr == `REG_STATUS)
          rdata_ff <= {11'h000, rx_act_ff, tx_act, rx_rd_ff, tx_rd_ff, sync_ff};
        else
          rdata_ff <= bad_cnt_ff;
      end
    end
  end
endmodule

//--- rtl/pcs_map.vh
// offsets, fields, reset values and code-group constants of the pcs codec
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
`define REG_CTRL       2'h0
`define REG_CFG        2'h1
`define REG_STATUS     2'h2
`define REG_BADCNT     2'h3
`define CTRL_XMIT_DATA 0
`define CTRL_RESET     16'h0001
`define CFG_RESET      16'h0000
`define ST_SYNC        0
`define ST_TX_RD       1
`define ST_RX_RD       2
`define ST_TX_ACT      3
`define ST_RX_ACT      4
`define OS_COMMA       8'hBC
`define OS_IDLE2       8'h50
`define OS_CFG1        8'hB5
`define OS_CFG2        8'h42
`define OS_START_PKT   8'hFB
`define OS_END_PKT     8'hFD
`define OS_CARRY       8'hF7
`define OS_ERR         8'hFE
`define RX_PREAMBLE    8'h55
`define SYNC_ACQ       3'h3
`define SYNC_LOSS      3'h4
`endif

//--- rtl/octet_to_codegroup.v
// 8b/10b table lookup for one octet at a given running disparity
`timescale 1ns/1ps
module octet_to_codegroup (
  input  wire [7:0] octet,
  input  wire       is_special,
  input  wire       rd_pos,
  output reg  [9:0] code
);
  reg [5:0] s6;
  reg [3:0] s4;
  reg       mid;
  reg       alt;
  reg [2:0] n6;
  reg [2:0] n4;
  integer   i;

  always @* begin
    case (octet[4:0])
      5'h00: s6 = 6'b100111;  5'h01: s6 = 6'b011101;
      5'h02: s6 = 6'b101101;  5'h03: s6 = 6'b110001;
      5'h04: s6 = 6'b110101;  5'h05: s6 = 6'b101001;
      5'h06: s6 = 6'b011001;  5'h07: s6 = 6'b111000;
      5'h08: s6 = 6'b111001;  5'h09: s6 = 6'b100101;
      5'h0A: s6 = 6'b010101;  5'h0B: s6 = 6'b110100;
      5'h0C: s6 = 6'b001101;  5'h0D: s6 = 6'b101100;
      5'h0E: s6 = 6'b011100;  5'h0F: s6 = 6'b010111;
      5'h10: s6 = 6'b011011;  5'h11: s6 = 6'b100011;
      5'h12: s6 = 6'b010011;  5'h13: s6 = 6'b110010;
      5'h14: s6 = 6'b001011;  5'h15: s6 = 6'b101010;
      5'h16: s6 = 6'b011010;  5'h17: s6 = 6'b111010;
      5'h18: s6 = 6'b110011;  5'h19: s6 = 6'b100110;
      5'h1A: s6 = 6'b010110;  5'h1B: s6 = 6'b110110;
      5'h1C: s6 = 6'b001110;  5'h1D: s6 = 6'b101110;
      5'h1E: s6 = 6'b011110;  default: s6 = 6'b101011;
    endcase
    if (is_special && octet[4:0] == 5'h1C)
      s6 = 6'b001111;
    n6 = 3'h0;
    for (i = 0; i < 6; i = i + 1)
      n6 = n6 + {2'h0, s6[i]};
    // positive disparity picks the complemented column
    if (rd_pos && (n6 != 3'h3 || s6 == 6'b111000))
      s6 = ~s6;
    n6 = 3'h0;
    for (i = 0; i < 6; i = i + 1)
      n6 = n6 + {2'h0, s6[i]};
    mid = (n6 > 3'h3) | (s6 == 6'b000111) |
          (rd_pos & (n6 == 3'h3) & (s6 != 6'b111000));
    // alternate x.7 avoids a run of five across the sub-blocks
    alt = is_special |
          (~mid & (octet[4:0] == 5'h11 || octet[4:0] == 5'h12 || octet[4:0] == 5'h14)) |
          (mid & (octet[4:0] == 5'h0B || octet[4:0] == 5'h0D || octet[4:0] == 5'h0E));
    case (octet[7:5])
      3'h0: s4 = 4'b1011;
      3'h1: s4 = 4'b1001;
      3'h2: s4 = 4'b0101;
      3'h3: s4 = 4'b1100;
      3'h4: s4 = 4'b1101;
      3'h5: s4 = 4'b1010;
      3'h6: s4 = 4'b0110;
      default: s4 = alt ? 4'b0111 : 4'b1110;
    endcase
    n4 = {2'h0, s4[0]} + {2'h0, s4[1]} + {2'h0, s4[2]} + {2'h0, s4[3]};
    if (is_special && octet[4:0] == 5'h1C && n4 == 3'h2 && s4 != 4'b1100) begin
      if (!mid)
        s4 = ~s4;
    end else if (mid && (n4 != 3'h2 || s4 == 4'b1100)) begin
      s4 = ~s4;
    end
    code = {s6, s4};
  end
endmodule

//--- dv/pcs_codec_checker_assertions.sv
// port-level assertions for the pcs codec
`timescale 1ns/1ps
module pcs_codec_checker (
  input wire        mclk,
  input wire        rst_n,
  input wire [9:0]  tx_code,
  input wire        rx_dv,
  input wire        rx_er,
  input wire        col,
  input wire        crs,
  input wire        sync_ok,
  input wire        reg_rd,
  input wire [15:0] reg_rdata
);
  // ----
  // tx stream position and disparity
  // ----
  logic live_ff;
  logic pos_ff;
  logic rd_ff;
  logic live_now;
  logic rd6;
  // the first nonzero group after reset is position zero
  assign live_now = live_ff | (tx_code != 10'h000);
  function automatic logic sub_rd(input logic rd, input int n, input int h, input logic p, input logic m);
    if (n > h || p) return 1'b1;
    if (n < h || m) return 1'b0;
    return rd;
  endfunction
  assign rd6 = sub_rd(rd_ff, $countones(tx_code[9:4]), 3, tx_code[9:4] == 6'h07, tx_code[9:4] == 6'h38);
  always @(posedge mclk) begin
    if (!rst_n) begin
      live_ff <= 1'b0;
      pos_ff  <= 1'b0;
      rd_ff   <= 1'b0;
    end else if (live_now) begin
      live_ff <= 1'b1;
      pos_ff  <= ~pos_ff;
      rd_ff   <= sub_rd(rd6, $countones(tx_code[3:0]), 2, tx_code[3:0] == 4'h3, tx_code[3:0] == 4'hC);
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  first_comma_a: assert property ($rose(rst_n) |-> ##[0:2] tx_code == 10'h0FA)
    else $error("no comma after reset");
  tx_balance_a: assert property (live_now |-> ($countones(tx_code) == 5 || $countones(tx_code) == (rd_ff ? 4 : 6)))
    else $error("group weight breaks disparity");
  comma_even_a: assert property (live_now && (tx_code == 10'h0FA || tx_code == 10'h305) |-> !pos_ff)
    else $error("comma on odd slot");
  col_crs_a: assert property (col |-> crs && $past(sync_ok))
    else $error("col without crs or sync");
  rx_crs_a: assert property (rx_dv |-> crs)
    else $error("rx_dv without crs");
  rx_er_dv_a: assert property (rx_er |-> rx_dv)
    else $error("rx_er without rx_dv");
  nosync_quiet_a: assert property ((!sync_ok) [*3] |-> !rx_dv)
    else $error("delivery while unsynced");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("rdata outside read slot");
endmodule

bind gigabit_pcs_8b10b_codec pcs_codec_checker chk_u (.mclk(mclk), .rst_n(rst_n), .tx_code(tx_code),
  .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs), .sync_ok(sync_ok), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- dv/pma_loopback.sv
// pma side model: loops transmit code-groups back to receive
`timescale 1ns/1ps
module pma_loopback (
  input  wire       mclk,
  input  wire [9:0] tx_code,
  input  wire       corrupt,
  output reg  [9:0] rx_code
);
  // ----
  // one group per clock, one cycle of line delay
  // ----
  initial rx_code = 10'h000;
  // all-zero group fits no column, so each corrupted slot is invalid
  always @(posedge mclk) begin
    rx_code <= corrupt ? 10'h000 : tx_code;
  end
endmodule

//--- dv/tb_gigabit_pcs_8b10b_codec.sv
// self-checking bench for the pcs codec over a pma loopback
`timescale 1ns/1ps
module tb_gigabit_pcs_8b10b_codec;
  // ----
  // signals
  // ----
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  txd = 8'h00;
  logic        tx_en = 1'b0;
  logic        tx_er = 1'b0;
  logic        corrupt = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [9:0]  tx_code, rx_code;
  wire  [7:0]  rxd;
  wire         rx_dv, rx_er, col, crs, sync_ok;
  wire  [15:0] reg_rdata;
  int          num_errors = 0;
  int          samples_checked = 0;
  bit          saw_col, saw_er;
  logic [7:0]  rx_q[$];
  logic [7:0]  pkt[5] = '{8'h00, 8'hFF, 8'hBC, 8'h55, 8'hB5};

  always #4 mclk = ~mclk;

  gigabit_pcs_8b10b_codec dut_u (.mclk(mclk), .rst_n(rst_n), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .tx_code(tx_code), .rx_code(rx_code), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs),
    .sync_ok(sync_ok), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  pma_loopback pma_u (.mclk(mclk), .tx_code(tx_code), .corrupt(corrupt), .rx_code(rx_code));

  always @(posedge mclk) begin
    if (rx_dv === 1'b1) rx_q.push_back(rxd);
    if (col === 1'b1) saw_col = 1'b1;
    if (rx_er === 1'b1) saw_er = 1'b1;
  end
  // ----
  // compare and run control
  // ----
  task automatic report(input bit bad, input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (bad) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_code(input string n, input logic [9:0] e, input logic [9:0] g);
    report(g !== e, n, {6'h00, e}, {6'h00, g});
  endtask
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    report(g !== e, n, e, g);
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    report(g !== e, n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // bus and stream tasks
  // ----
  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  // gap cycle after each strobe keeps one assignment per time step
  task automatic reg_write(input logic [1:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask
  task automatic wait_code(input logic [9:0] a, input logic [9:0] b);
    int i;
    for (i = 0; i < 60 && tx_code !== a && tx_code !== b; i++) @(posedge mclk);
    chk_bit("tx_code_found", 1'b1, tx_code === a || tx_code === b);
    if (tx_code !== a && tx_code !== b) complete_run();
  endtask
  task automatic wait_sync(input logic want);
    int i;
    for (i = 0; i < 200 && sync_ok !== want; i++) @(posedge mclk);
    chk_bit("sync_ok", want, sync_ok);
    if (sync_ok !== want) complete_run();
  endtask
  task automatic idle_check();
    int k;
    do_reset();
    wait_code(10'h0FA, 10'h0FA);
    for (k = 0; k < 6; k++) begin
      @(posedge mclk);
      chk_code("idle", k[0] ? 10'h0FA : 10'h245, tx_code);
    end
  endtask
  task automatic send_pkt(input bit err);
    int i;
    logic [9:0] sd;
    wait_code(10'h0FA, 10'h305);
    // idle polarity is fixed by the last packet, so pick the column from it
    sd = (tx_code === 10'h0FA) ? 10'h368 : 10'h097;
    rx_q.delete();
    saw_col = 1'b0;
    saw_er = 1'b0;
    tx_en <= 1'b1;
    for (i = 0; i < 5; i++) begin
      @(posedge mclk);
      txd <= pkt[i];
      tx_er <= err && i == 2;
      if (i == 1) chk_code("start_delim", sd, tx_code);
    end
    @(posedge mclk);
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    repeat (30) @(posedge mclk);
    chk_bit("col_seen", 1'b1, saw_col);
    chk_bit("crs_end", 1'b0, crs);
    chk_bit("rx_er_seen", err, saw_er);
    if (!err) begin
      chk_reg("rx_len", 16'h0006, 16'(rx_q.size()));
      for (i = 0; i < 6; i++) chk_reg("rxd", {8'h00, i == 0 ? 8'h55 : pkt[i - 1]}, {8'h00, rx_q[i]});
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] d;
    idle_check();
    wait_sync(1'b1);
    reg_read(2'h0, d);
    chk_reg("ctrl", 16'h0001, d);
    reg_read(2'h1, d);
    chk_reg("cfg", 16'h0000, d);
    reg_read(2'h2, d);
    chk_reg("status_sync", 16'h0001, d & 16'h0001);
    reg_write(2'h3, 16'h0000);
    reg_read(2'h3, d);
    chk_reg("badcnt", 16'h0000, d);
    send_pkt(1'b0);
    send_pkt(1'b1);
    corrupt <= 1'b1;
    wait_sync(1'b0);
    corrupt <= 1'b0;
    wait_sync(1'b1);
    reg_read(2'h3, d);
    chk_bit("badcnt_min", 1'b1, d >= 16'h0004);
    send_pkt(1'b0);
    reg_write(2'h1, 16'h1234);
    reg_write(2'h0, 16'hFFFE);
    reg_read(2'h0, d);
    chk_reg("ctrl_cfg_mode", 16'h0000, d);
    reg_read(2'h1, d);
    chk_reg("cfg_word", 16'h1234, d);
    wait_code(10'h2AA, 10'h2AA);
    repeat (3) @(posedge mclk);
    chk_bit("cfg_comma", 1'b1, tx_code === 10'h0FA || tx_code === 10'h305);
    reg_write(2'h0, 16'h0001);
    wait_code(10'h245, 10'h1B5);
    idle_check();
    complete_run();
  end
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule
